// ### core/cax_pkg.sv
package cax_pkg;

    // Status register bit positions.
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // Values after reset.
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Cycle counts of each instruction class.
    localparam logic [2:0] CYC_ALU = 3'h1;
    localparam logic [2:0] CYC_WORD = 3'h2;
    localparam logic [2:0] CYC_MUL = 3'h2;
    localparam logic [2:0] CYC_REL_JUMP = 3'h2;
    localparam logic [2:0] CYC_REL_CALL = 3'h3;
    localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
    localparam logic [2:0] CYC_PTR_CALL = 3'h3;
    localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
    localparam logic [2:0] CYC_ABS_CALL = 3'h4;
    localparam logic [2:0] CYC_RETURN = 3'h4;
    localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
    localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
    localparam logic [2:0] CYC_BR_TAKEN = 3'h2;

    // Operation codes presented by the fetch stage.
    typedef enum logic [5:0] {
        OP_NOP = 6'h00, OP_ADD = 6'h01, OP_ADD_CARRY = 6'h02,
        OP_WORD_IMMEDIATE_ADD = 6'h03, OP_WORD_IMMEDIATE_SUBTRACT = 6'h04,
        OP_SUB_REG = 6'h05, OP_SUBTRACT_CONSTANT_OP = 6'h06,
        OP_SUBTRACT_WITH_BORROW = 6'h07, OP_SUBTRACT_CONSTANT_WITH_BORROW = 6'h08,
        OP_AND_REG = 6'h09, OP_AND_WITH_CONSTANT = 6'h0A, OP_OR_REG = 6'h0B,
        OP_OR_WITH_CONSTANT = 6'h0C, OP_EXCLUSIVE_OR_OP = 6'h0D,
        OP_SET_MASK_BITS = 6'h0E, OP_CLEAR_MASK_BITS = 6'h0F, OP_ZERO_MINUS_TEST = 6'h10,
        OP_UNSIGNED_MULTIPLY = 6'h11, OP_SIGNED_MULTIPLY = 6'h12, OP_MIXED_SIGN_MULTIPLY = 6'h13,
        OP_FRACTIONAL_UNSIGNED_MULTIPLY = 6'h14, OP_FRACTIONAL_SIGNED_MULTIPLY = 6'h15,
        OP_FRACTIONAL_MIXED_MULTIPLY = 6'h16,
        OP_RELATIVE_JUMP = 6'h17, OP_RELATIVE_CALL = 6'h18, OP_POINTER_JUMP = 6'h19,
        OP_POINTER_CALL = 6'h1A, OP_ABSOLUTE_JUMP = 6'h1B, OP_ABSOLUTE_CALL = 6'h1C,
        OP_SUBROUTINE_RETURN = 6'h1D, OP_INTERRUPT_RETURN = 6'h1E,
        OP_COMPARE_SKIP_EQUAL = 6'h1F, OP_COMPARE_REG = 6'h20, OP_COMPARE_WITH_CARRY = 6'h21,
        OP_COMPARE_IMMEDIATE = 6'h22, OP_SKIP_REG_BIT_CLEAR = 6'h23, OP_SKIP_REG_BIT_SET = 6'h24,
        OP_SKIP_IO_BIT_CLEAR = 6'h25, OP_SKIP_IO_BIT_SET = 6'h26,
        OP_BRANCH_FLAG_SET = 6'h27, OP_BRANCH_FLAG_CLEAR = 6'h28,
        OP_BRANCH_SIGNED_GE = 6'h29, OP_BRANCH_SIGNED_LT = 6'h2A,
        OP_BRANCH_UNSIGNED_SAME_HIGHER = 6'h2B, OP_BRANCH_UNSIGNED_LOWER = 6'h2C,
        OP_BRANCH_IRQ_ENABLED = 6'h2D, OP_BRANCH_IRQ_DISABLED = 6'h2E
    } cax_op_e;

endpackage

// ### core/cax_execute.sv
// How it works
// - Plain add writes the 8-bit sum, updates Z C N V H, one cycle.
// - Add with carry also adds the carry flag, same flags, one cycle.
// - Word add/subtract of a constant on a pair, flags Z C N V S, two cycles.
// - Register or constant subtract writes the difference, Z C N V H, one cycle.
// - Borrow subtracts also take off the carry flag, Z C N V H, one cycle.
// - AND, OR and exclusive OR write the result, update only Z N V, one cycle.
// - Mask set ORs the constant in, mask clear ANDs with its complement.
// - Zero-or-minus test ANDs a register with itself, sets Z N V, no write.
// - Multiplies put the 16-bit product into pair one:zero, Z and C, two cycles.
// - Fractional multiplies shift the product left once first, two cycles.
// - Relative jump and call go to PC plus offset plus one, two and three cycles.
// - Pointer jump and call load PC from Z, two and three cycles.
// - Absolute jump and call load the carried address, three and four cycles.
// - Compare-skip-equal skips the next instruction when both registers match.
// - Compares compute a difference without storing it, Z N V C H, one cycle.
// - Register-bit skips test one bit and skip on clear or on set.
// - I/O-bit skips test one bit of an I/O value, flags untouched.
// - Flag branches go to PC plus offset plus one when taken, one or two cycles.
// - Signed branches decide on N xor V, one or two cycles.
// - Named branches cover N xor V, carry as same-or-higher and lower, and the I flag.
module cax_execute
    import cax_pkg::*;
(
    // Clock and reset.
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    // Decoded instruction from fetch.
    input wire logic OP_VALID_I,
    input wire cax_op_e OP_CODE_I,
    input wire logic [7:0] OP_RD_I,
    input wire logic [7:0] OP_RDH_I,
    input wire logic [7:0] OP_RR_I,
    input wire logic [15:0] OP_K_I,
    input wire logic [2:0] OP_BIT_I,
    input wire logic [7:0] IO_VAL_I,
    input wire logic NEXT_TWO_WORD_I,
    input wire logic [15:0] Z_PTR_I,
    input wire logic [15:0] STACK_PC_I,
    // Handshake and core state.
    output logic READY_O,
    output logic DONE_O,
    output logic [15:0] PC_O,
    output logic [7:0] STATUS_O,
    // Register file write-back.
    output logic WB_EN_O,
    output logic [7:0] WB_DATA_O,
    output logic PAIR_EN_O,
    output logic PAIR_MUL_O,
    output logic [15:0] PAIR_O,
    // Stack requests.
    output logic PUSH_EN_O,
    output logic [15:0] PUSH_PC_O,
    output logic POP_EN_O
);

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] status;
        logic wb_en;
        logic [7:0] wb;
        logic pair_en;
        logic pair_mul;
        logic [15:0] pair;
        logic push_en;
        logic [15:0] push;
        logic pop_en;
    } cax_commit_s;

    typedef struct packed {
        logic ready;
        logic [2:0] cnt;
        logic done;
        cax_commit_s pend;
        cax_commit_s cur;
    } cax_state_s;

    localparam cax_state_s STATE_RESET = '{ready: 1'b1, cnt: 3'h0, done: 1'b0, pend: '0,
        cur: '{pc: RESET_PC, status: STATUS_RESET, default: '0}};

    cax_state_s r_reg;
    cax_state_s r_next;
    cax_commit_s f;
    logic accept;
    logic [2:0] cyc;
    logic [9:0] t8;
    logic [16:0] t16;
    logic signed [17:0] prod;
    logic [15:0] p16;
    logic [7:0] opnd;
    logic cin;
    logic cond;
    logic [15:0] rel_pc;

    // Add with half carry: returns {half, carry, sum}.
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [4:0] lo;
        logic [8:0] s;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        return {lo[4], s};
    endfunction

    // Subtract with half borrow: returns {half, borrow, difference}.
    function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [4:0] lo;
        logic [8:0] s;
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        return {lo[4], s};
    endfunction

    // Flags of a byte add or subtract; S is left alone here.
    function automatic logic [7:0] arith_flags(input logic [7:0] st, input logic [7:0] a,
                                               input logic [7:0] b, input logic [9:0] t, input logic sub);
        logic [7:0] o;
        o = st;
        o[FLAG_H] = t[9];
        o[FLAG_C] = t[8];
        o[FLAG_N] = t[7];
        o[FLAG_Z] = (t[7:0] == 8'h00);
        o[FLAG_V] = sub ? ((a[7] != b[7]) && (t[7] != a[7])) : ((a[7] == b[7]) && (t[7] != a[7]));
        return o;
    endfunction

    // Flags of a logic operation: overflow always cleared.
    function automatic logic [7:0] logic_flags(input logic [7:0] st, input logic [7:0] res);
        logic [7:0] o;
        o = st;
        o[FLAG_Z] = (res == 8'h00);
        o[FLAG_N] = res[7];
        o[FLAG_V] = 1'b0;
        return o;
    endfunction

    assign accept = OP_VALID_I && r_reg.ready;
    assign rel_pc = r_reg.cur.pc + OP_K_I + 16'h0001;

    // Execute the accepted operation into a fresh commit record.
    always_comb begin
        f = '0;
        f.pc = r_reg.cur.pc + 16'h0001;
        f.status = r_reg.cur.status;
        f.wb = r_reg.cur.wb;
        cyc = CYC_ALU;
        t8 = '0;
        t16 = '0;
        prod = '0;
        p16 = '0;
        opnd = OP_RR_I;
        cin = 1'b0;
        cond = 1'b0;
        unique case (OP_CODE_I)
            OP_ADD, OP_ADD_CARRY: begin
                cin = (OP_CODE_I == OP_ADD_CARRY) && r_reg.cur.status[FLAG_C];
                t8 = add8(OP_RD_I, OP_RR_I, cin);
                f.status = arith_flags(r_reg.cur.status, OP_RD_I, OP_RR_I, t8, 1'b0);
                f.wb = t8[7:0];
                f.wb_en = 1'b1;
            end
            OP_SUB_REG, OP_SUBTRACT_CONSTANT_OP, OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_CONSTANT_WITH_BORROW,
            OP_COMPARE_REG, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE: begin
                if (OP_CODE_I inside {OP_SUBTRACT_CONSTANT_OP, OP_SUBTRACT_CONSTANT_WITH_BORROW,
                                      OP_COMPARE_IMMEDIATE}) begin
                    opnd = OP_K_I[7:0];
                end
                cin = (OP_CODE_I inside {OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_CONSTANT_WITH_BORROW,
                                         OP_COMPARE_WITH_CARRY}) && r_reg.cur.status[FLAG_C];
                t8 = sub8(OP_RD_I, opnd, cin);
                f.status = arith_flags(r_reg.cur.status, OP_RD_I, opnd, t8, 1'b1);
                f.wb = t8[7:0];
                // Compares keep the destination untouched.
                f.wb_en = !(OP_CODE_I inside {OP_COMPARE_REG, OP_COMPARE_WITH_CARRY,
                                              OP_COMPARE_IMMEDIATE});
            end
            OP_AND_REG, OP_AND_WITH_CONSTANT, OP_OR_REG, OP_OR_WITH_CONSTANT, OP_EXCLUSIVE_OR_OP,
            OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_ZERO_MINUS_TEST: begin
                unique case (OP_CODE_I)
                    OP_AND_REG: f.wb = OP_RD_I & OP_RR_I;
                    OP_AND_WITH_CONSTANT: f.wb = OP_RD_I & OP_K_I[7:0];
                    OP_OR_REG: f.wb = OP_RD_I | OP_RR_I;
                    OP_OR_WITH_CONSTANT: f.wb = OP_RD_I | OP_K_I[7:0];
                    OP_EXCLUSIVE_OR_OP: f.wb = OP_RD_I ^ OP_RR_I;
                    OP_SET_MASK_BITS: f.wb = OP_RD_I | OP_K_I[7:0];
                    OP_CLEAR_MASK_BITS: f.wb = OP_RD_I & (8'hFF - OP_K_I[7:0]);
                    default: f.wb = OP_RD_I & OP_RD_I;
                endcase
                f.status = logic_flags(r_reg.cur.status, f.wb);
                f.wb_en = (OP_CODE_I != OP_ZERO_MINUS_TEST);
            end
            OP_WORD_IMMEDIATE_ADD, OP_WORD_IMMEDIATE_SUBTRACT: begin
                // The constant is zero-extended; carry is the 16-bit carry or borrow.
                if (OP_CODE_I == OP_WORD_IMMEDIATE_ADD) begin
                    t16 = {1'b0, OP_RDH_I, OP_RD_I} + {9'h000, OP_K_I[7:0]};
                    f.status[FLAG_V] = !OP_RDH_I[7] && t16[15];
                end else begin
                    t16 = {1'b0, OP_RDH_I, OP_RD_I} - {9'h000, OP_K_I[7:0]};
                    f.status[FLAG_V] = OP_RDH_I[7] && !t16[15];
                end
                f.status[FLAG_C] = t16[16];
                f.status[FLAG_N] = t16[15];
                f.status[FLAG_Z] = (t16[15:0] == 16'h0000);
                f.status[FLAG_S] = t16[15] ^ f.status[FLAG_V];
                f.pair = t16[15:0];
                f.pair_en = 1'b1;
                cyc = CYC_WORD;
            end
            OP_UNSIGNED_MULTIPLY, OP_SIGNED_MULTIPLY, OP_MIXED_SIGN_MULTIPLY, OP_FRACTIONAL_UNSIGNED_MULTIPLY,
            OP_FRACTIONAL_SIGNED_MULTIPLY, OP_FRACTIONAL_MIXED_MULTIPLY: begin
                // One 9x9 signed multiplier serves all six; extension picks the signedness.
                prod = $signed({OP_RD_I[7] && !(OP_CODE_I inside {OP_UNSIGNED_MULTIPLY,
                                OP_FRACTIONAL_UNSIGNED_MULTIPLY}), OP_RD_I})
                     * $signed({OP_RR_I[7] && (OP_CODE_I inside {OP_SIGNED_MULTIPLY,
                                OP_FRACTIONAL_SIGNED_MULTIPLY}), OP_RR_I});
                p16 = prod[15:0];
                f.status[FLAG_C] = p16[15];
                if (OP_CODE_I inside {OP_FRACTIONAL_UNSIGNED_MULTIPLY, OP_FRACTIONAL_SIGNED_MULTIPLY,
                                      OP_FRACTIONAL_MIXED_MULTIPLY}) begin
                    p16 = {p16[14:0], 1'b0};
                end
                f.status[FLAG_Z] = (p16 == 16'h0000);
                f.pair = p16;
                f.pair_en = 1'b1;
                f.pair_mul = 1'b1;
                cyc = CYC_MUL;
            end
            OP_RELATIVE_JUMP, OP_RELATIVE_CALL: begin
                f.pc = rel_pc;
                f.push = r_reg.cur.pc + 16'h0001;
                f.push_en = (OP_CODE_I == OP_RELATIVE_CALL);
                cyc = f.push_en ? CYC_REL_CALL : CYC_REL_JUMP;
            end
            OP_POINTER_JUMP, OP_POINTER_CALL: begin
                f.pc = Z_PTR_I;
                f.push = r_reg.cur.pc + 16'h0001;
                f.push_en = (OP_CODE_I == OP_POINTER_CALL);
                cyc = f.push_en ? CYC_PTR_CALL : CYC_PTR_JUMP;
            end
            OP_ABSOLUTE_JUMP, OP_ABSOLUTE_CALL: begin
                // Both are two words long, so the return point skips the address word.
                f.pc = OP_K_I;
                f.push = r_reg.cur.pc + 16'h0002;
                f.push_en = (OP_CODE_I == OP_ABSOLUTE_CALL);
                cyc = f.push_en ? CYC_ABS_CALL : CYC_ABS_JUMP;
            end
            OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN: begin
                f.pc = STACK_PC_I;
                f.pop_en = 1'b1;
                f.status[FLAG_I] = r_reg.cur.status[FLAG_I] || (OP_CODE_I == OP_INTERRUPT_RETURN);
                cyc = CYC_RETURN;
            end
            OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
            OP_SKIP_IO_BIT_SET: begin
                unique case (OP_CODE_I)
                    OP_COMPARE_SKIP_EQUAL: cond = (OP_RD_I == OP_RR_I);
                    OP_SKIP_REG_BIT_CLEAR: cond = !OP_RR_I[OP_BIT_I];
                    OP_SKIP_REG_BIT_SET: cond = OP_RR_I[OP_BIT_I];
                    OP_SKIP_IO_BIT_CLEAR: cond = !IO_VAL_I[OP_BIT_I];
                    default: cond = IO_VAL_I[OP_BIT_I];
                endcase
                // The skipped instruction's length decides between two and three cycles.
                if (cond) begin
                    f.pc = r_reg.cur.pc + (NEXT_TWO_WORD_I ? 16'h0003 : 16'h0002);
                    cyc = NEXT_TWO_WORD_I ? CYC_SKIP_TWO : CYC_SKIP_ONE;
                end
            end
            OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
            OP_BRANCH_UNSIGNED_SAME_HIGHER, OP_BRANCH_UNSIGNED_LOWER, OP_BRANCH_IRQ_ENABLED,
            OP_BRANCH_IRQ_DISABLED: begin
                unique case (OP_CODE_I)
                    OP_BRANCH_FLAG_SET: cond = r_reg.cur.status[OP_BIT_I];
                    OP_BRANCH_FLAG_CLEAR: cond = !r_reg.cur.status[OP_BIT_I];
                    OP_BRANCH_SIGNED_GE: cond = !(r_reg.cur.status[FLAG_N] ^ r_reg.cur.status[FLAG_V]);
                    OP_BRANCH_SIGNED_LT: cond = r_reg.cur.status[FLAG_N] ^ r_reg.cur.status[FLAG_V];
                    OP_BRANCH_UNSIGNED_SAME_HIGHER: cond = !r_reg.cur.status[FLAG_C];
                    OP_BRANCH_UNSIGNED_LOWER: cond = r_reg.cur.status[FLAG_C];
                    OP_BRANCH_IRQ_ENABLED: cond = r_reg.cur.status[FLAG_I];
                    default: cond = !r_reg.cur.status[FLAG_I];
                endcase
                if (cond) begin
                    f.pc = rel_pc;
                    cyc = CYC_BR_TAKEN;
                end
            end
            default: begin
                f.pc = r_reg.cur.pc + 16'h0001;
            end
        endcase
    end

    // Sequencer: one-cycle work commits at once, longer work waits out its count.
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.cur.wb_en = 1'b0;
        r_next.cur.pair_en = 1'b0;
        r_next.cur.push_en = 1'b0;
        r_next.cur.pop_en = 1'b0;
        if (accept && (cyc == CYC_ALU)) begin
            r_next.cur = f;
            r_next.done = 1'b1;
        end else if (accept) begin
            r_next.pend = f;
            r_next.cnt = cyc - 3'h1;
            r_next.ready = 1'b0;
        end else if (!r_reg.ready) begin
            r_next.cnt = r_reg.cnt - 3'h1;
            if (r_reg.cnt == 3'h1) begin
                r_next.cur = r_reg.pend;
                r_next.done = 1'b1;
                r_next.ready = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            r_reg <= STATE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // Every output is a field of the state register.
    assign READY_O = r_reg.ready;
    assign DONE_O = r_reg.done;
    assign PC_O = r_reg.cur.pc;
    assign STATUS_O = r_reg.cur.status;
    assign WB_EN_O = r_reg.cur.wb_en;
    assign WB_DATA_O = r_reg.cur.wb;
    assign PAIR_EN_O = r_reg.cur.pair_en;
    assign PAIR_MUL_O = r_reg.cur.pair_mul;
    assign PAIR_O = r_reg.cur.pair;
    assign PUSH_EN_O = r_reg.cur.push_en;
    assign PUSH_PC_O = r_reg.cur.push;
    assign POP_EN_O = r_reg.cur.pop_en;

    // Checks on timing and results.
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    a_add_sum_write: assert property (accept && OP_CODE_I == OP_ADD |=>
        DONE_O && WB_EN_O && WB_DATA_O == 8'($past(OP_RD_I) + $past(OP_RR_I)))
        else $error("Plain add wrote a wrong sum.");
    a_word_two_cycles: assert property (accept && OP_CODE_I inside {OP_WORD_IMMEDIATE_ADD,
        OP_WORD_IMMEDIATE_SUBTRACT} |=> !DONE_O ##1 DONE_O && PAIR_EN_O && !PAIR_MUL_O)
        else $error("Word operation did not finish in two cycles.");
    a_sub_borrow_flag: assert property (accept && OP_CODE_I == OP_SUB_REG |=>
        STATUS_O[FLAG_C] == ($past(OP_RR_I) > $past(OP_RD_I)))
        else $error("Subtract borrow flag wrong.");
    a_logic_flag_set: assert property (accept && OP_CODE_I inside {OP_AND_REG, OP_OR_REG,
        OP_EXCLUSIVE_OR_OP} |=> !STATUS_O[FLAG_V] && STATUS_O[FLAG_Z] == (WB_DATA_O == 8'h00))
        else $error("Logic operation flags wrong.");
    a_mul_pair_out: assert property (accept && OP_CODE_I == OP_UNSIGNED_MULTIPLY |=>
        !DONE_O ##1 PAIR_EN_O && PAIR_MUL_O && PAIR_O == 16'($past(OP_RD_I, 2) * $past(OP_RR_I, 2)))
        else $error("Unsigned product wrong or late.");
    a_rel_jump_target: assert property (accept && OP_CODE_I == OP_RELATIVE_JUMP |=>
        ##1 DONE_O && PC_O == 16'($past(PC_O, 2) + $past(OP_K_I, 2) + 16'h0001))
        else $error("Relative jump target wrong.");
    a_abs_call_four: assert property (accept && OP_CODE_I == OP_ABSOLUTE_CALL |=>
        !DONE_O [*3] ##1 DONE_O && PUSH_EN_O && PC_O == $past(OP_K_I, 4))
        else $error("Absolute call not done in four cycles.");
    a_irq_return_sets: assert property (accept && OP_CODE_I == OP_INTERRUPT_RETURN |=>
        !DONE_O [*3] ##1 DONE_O && POP_EN_O && STATUS_O[FLAG_I])
        else $error("Interrupt return did not restore and enable.");
    a_skip_equal_pc: assert property (accept && OP_CODE_I == OP_COMPARE_SKIP_EQUAL &&
        OP_RD_I == OP_RR_I && !NEXT_TWO_WORD_I |=> ##1 DONE_O && PC_O == 16'($past(PC_O, 2) + 16'h0002))
        else $error("Equal compare did not skip one word.");
    a_branch_not_taken: assert property (accept && OP_CODE_I == OP_BRANCH_FLAG_SET &&
        !STATUS_O[OP_BIT_I] |=> DONE_O && PC_O == 16'($past(PC_O) + 16'h0001))
        else $error("Untaken branch did not fall through.");
    a_signed_lt_taken: assert property (accept && OP_CODE_I == OP_BRANCH_SIGNED_LT &&
        (STATUS_O[FLAG_N] ^ STATUS_O[FLAG_V]) |=> !DONE_O ##1 DONE_O)
        else $error("Taken signed branch not two cycles.");

endmodule // cax_execute

// ### verif/cax_stack_model.sv
module cax_stack_model (
    // Clock and push request.
    input wire logic clk_i,
    input wire logic push_i,
    input wire logic [15:0] push_pc_i,
    // Values sampled at accept.
    output logic [15:0] z_ptr_o,
    output logic [15:0] stack_pc_o,
    output logic [7:0] io_val_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] top_reg = 16'h0000;
    // Fixed pointer and port values keep targets predictable.
    assign z_ptr_o = 16'h1234;
    assign io_val_o = 8'ha5;
    // A push of the same edge is forwarded, since the core reads at accept.
    assign stack_pc_o = push_i ? push_pc_i : top_reg;
    // Only the top entry is held; returns here never nest deeper.
    always @(posedge clk_i) if (push_i) top_reg <= push_pc_i;
endmodule // cax_stack_model

// ### verif/cpu_alu_and_branch_execute_tb.sv
module cpu_alu_and_branch_execute_tb
    import cax_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [5:0] op; logic [7:0] rd, rr; logic [15:0] k; int n; logic [15:0] pc;
        logic [7:0] st; int e; logic [15:0] d;} cax_row_s;
    logic clk, rst_n, vld, rdy, done, wb, pe, pm, pu, po;
    logic [7:0] rd, rr, io, st, wd;
    logic [15:0] k, z, stk, pc, pr, pp;
    cax_op_e op;
    int num_errors, compares;
    logic [4:0] msk [6] = '{5'h00, 5'h10, 5'h08, 5'h0c, 5'h02, 5'h01};
    cax_row_s rows [46] = '{
        '{'h01,'hf,'h1,'h0,1,'h1,'h20,1,'h10}, '{'h02,'hff,'h1,'h0,1,'h2,'h23,1,'h0},
        '{'h05,'h0,'h1,'h0,1,'h3,'h25,1,'hff}, '{'h07,'h80,'h0,'h0,1,'h4,'h28,1,'h7f},
        '{'h06,'h5,'h0,'h5,1,'h5,'h2,1,'h0}, '{'h08,'h5,'h0,'h3,1,'h6,'h0,1,'h2},
        '{'h09,'hf0,'h8f,'h0,1,'h7,'h4,1,'h80}, '{'h0a,'h3c,'h0,'hf,1,'h8,'h0,1,'hc},
        '{'h0b,'h1,'h2,'h0,1,'h9,'h0,1,'h3}, '{'h0c,'h0,'h0,'h0,1,'ha,'h2,1,'h0},
        '{'h0d,'haa,'h55,'h0,1,'hb,'h4,1,'hff}, '{'h0e,'h1,'h0,'h80,1,'hc,'h4,1,'h81},
        '{'h0f,'hff,'h0,'hf,1,'hd,'h4,1,'hf0}, '{'h10,'h0,'h0,'h0,1,'he,'h2,0,'h0},
        '{'h03,'hff,'h7f,'h1,2,'hf,'hc,2,'h8000}, '{'h04,'h0,'h0,'h1,2,'h10,'h15,2,'hffff},
        '{'h11,'hff,'hff,'h0,2,'h11,'h15,3,'hfe01}, '{'h12,'hff,'h2,'h0,2,'h12,'h15,3,'hfffe},
        '{'h13,'hff,'hff,'h0,2,'h13,'h15,3,'hff01}, '{'h14,'h80,'h80,'h0,2,'h14,'h14,3,'h8000},
        '{'h15,'h0,'h5,'h0,2,'h15,'h16,3,'h0}, '{'h16,'hff,'hff,'h0,2,'h16,'h15,3,'hfe02},
        '{'h22,'h0,'h0,'h1,1,'h17,'h35,0,'h0}, '{'h21,'h1,'h0,'h0,1,'h18,'h12,0,'h0},
        '{'h20,'h10,'h10,'h0,1,'h19,'h12,0,'h0}, '{'h27,'h1,'h0,'h10,2,'h2a,'h12,0,'h0},
        '{'h28,'h1,'h0,'h10,1,'h2b,'h12,0,'h0}, '{'h29,'h0,'h0,'hfffe,2,'h2a,'h12,0,'h0},
        '{'h2a,'h0,'h0,'h10,1,'h2b,'h12,0,'h0}, '{'h2b,'h0,'h0,'h0,2,'h2c,'h12,0,'h0},
        '{'h2c,'h0,'h0,'h10,1,'h2d,'h12,0,'h0}, '{'h2e,'h0,'h0,'h1,2,'h2f,'h12,0,'h0},
        '{'h2d,'h0,'h0,'h10,1,'h30,'h12,0,'h0}, '{'h1f,'h5,'h5,'h0,2,'h32,'h12,0,'h0},
        '{'h23,'h80,'hfe,'h0,3,'h35,'h12,0,'h0}, '{'h24,'h0,'hfe,'h0,1,'h36,'h12,0,'h0},
        '{'h25,'h1,'h0,'h0,2,'h38,'h12,0,'h0}, '{'h26,'h80,'h0,'h0,3,'h3b,'h12,0,'h0},
        '{'h17,'h0,'h0,'h100,2,'h13c,'h12,0,'h0}, '{'h18,'h0,'h0,'hffff,3,'h13c,'h12,4,'h13d},
        '{'h19,'h0,'h0,'h0,2,'h1234,'h12,0,'h0}, '{'h1a,'h0,'h0,'h0,3,'h1234,'h12,4,'h1235},
        '{'h1b,'h0,'h0,'h2000,3,'h2000,'h12,0,'h0}, '{'h1c,'h0,'h0,'h3000,4,'h3000,'h12,4,'h2002},
        '{'h1d,'h0,'h0,'h0,4,'h2002,'h12,5,'h0}, '{'h1e,'h0,'h0,'h0,4,'h2002,'h92,5,'h0}};
    // Bit select and next-instruction length ride on spare bits of the destination byte.
    cax_execute uut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .OP_VALID_I(vld), .OP_CODE_I(op), .OP_RD_I(rd),
        .OP_RDH_I(rr), .OP_RR_I(rr), .OP_K_I(k), .OP_BIT_I(rd[2:0]), .IO_VAL_I(io), .NEXT_TWO_WORD_I(rd[7]),
        .Z_PTR_I(z), .STACK_PC_I(stk), .READY_O(rdy), .DONE_O(done), .PC_O(pc), .STATUS_O(st), .WB_EN_O(wb),
        .WB_DATA_O(wd), .PAIR_EN_O(pe), .PAIR_MUL_O(pm), .PAIR_O(pr), .PUSH_EN_O(pu), .PUSH_PC_O(pp),
        .POP_EN_O(po));
    cax_stack_model model (.clk_i(clk), .push_i(pu), .push_pc_i(pp), .z_ptr_o(z), .stack_pc_o(stk), .io_val_o(io));
    // Core clock at 20 MHz.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Compares one value and counts it.
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
            num_errors++;
        if (g !== e)
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    endtask
    // Valid stays up between rows, so single-cycle rows run back to back and busy cycles test refusal.
    task automatic run(input cax_row_s w);
        int c;
        op = cax_op_e'(w.op);
        rd = w.rd;
        rr = w.rr;
        k = w.k;
        vld = 1'b1;
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (done !== 1'b1 && c < 8);
        chk(16'h0003, {14'h0000, rdy, done});
        if (done !== 1'b1)
            summarize();
        chk(16'(w.n), 16'(c));
        chk(w.pc, pc);
        chk({8'h00, w.st}, {8'h00, st});
        chk({11'h000, msk[w.e]}, {11'h000, wb, pe, pm, pu, po});
        if (w.e inside {[1:4]})
            chk(w.d, wb ? {8'h00, wd} : (pe ? pr : pp));
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Reset, every operation as a row, then a reset in mid-run.
    initial begin
        {rst_n, vld, rd, rr, k, num_errors, compares} = '0;
        op = OP_NOP;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            run(rows[i]);
            $display("row %0d done", i);
        end
        // The table never leaves a flag-set branch untaken or takes the signed-less branch.
        run(cax_row_s'{6'h27, 8'h00, 8'h00, 16'h0010, 1, 16'h2003, 8'h92, 0, 16'h0000});
        run(cax_row_s'{6'h05, 8'h00, 8'h01, 16'h0000, 1, 16'h2004, 8'hb5, 1, 16'h00ff});
        run(cax_row_s'{6'h2a, 8'h00, 8'h00, 16'h0010, 2, 16'h2015, 8'hb5, 0, 16'h0000});
        $display("branch tests done");
        rst_n = 1'b0;
        vld = 1'b0;
        @(negedge clk);
        chk(16'h0000, pc);
        chk({8'h00, STATUS_RESET}, {8'h00, st});
        chk(16'h0002, {14'h0000, rdy, done});
        rst_n = 1'b1;
        // A no-op offered in the first cycle after release only steps the counter.
        run(cax_row_s'{6'h00, 8'h00, 8'h00, 16'h0000, 1, 16'h0001, 8'h00, 0, 16'h0000});
        $display("reset test done");
        summarize();
    end
endmodule // cpu_alu_and_branch_execute_tb
